// ### shared/accum_alert_pkg.sv
// Constants shared by the control/status register block.
// Assumes byte-wide register accesses delivered by the serial front end.
package accum_alert_pkg;
    // ----------------------------------------
    // Register offsets
    // ----------------------------------------
    localparam logic [7:0] ADDR_STATUS_FLAGS = 8'h80;
    localparam logic [7:0] ADDR_GPIO_GATE = 8'he3;
    localparam logic [7:0] ADDR_DEADBAND = 8'he4;
    localparam logic [7:0] ADDR_ALERT_ENABLE = 8'he8;
    localparam logic [7:0] ADDR_TIMEBASE = 8'he9;
    // ----------------------------------------
    // Reset values
    // ----------------------------------------
    localparam logic [7:0] RST_DEADBAND = 8'h00;
    localparam logic [7:0] RST_ALERT_ENABLE = 8'h01;
    localparam logic [7:0] RST_TIMEBASE = 8'h07;
    localparam logic [7:0] RST_GPIO_GATE = 8'h00;
    localparam logic [7:0] RST_STATUS_POWER_UP = 8'h0f;
    localparam logic [7:0] RST_STATUS_SHUTDOWN_EXIT = 8'h09;
    localparam logic [7:0] READ_UNMAPPED = 8'h00;
    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int ALERT_PIN_ENABLE_BIT = 0;
    localparam int PRESCALE_LSB = 0;
    localparam int PRESCALE_MSB = 2;
    localparam int DIVIDER_LSB = 3;
    localparam int DIVIDER_MSB = 7;
    localparam logic [2:0] PRESCALE_INTERNAL = 3'h7;
    localparam int GATE1_LSB = 0;
    localparam int GATE2_LSB = 2;
    localparam int STAT_ANALOG_UV = 0;
    localparam int STAT_ANALOG_POR = 1;
    localparam int STAT_STANDBY_UV = 2;
    localparam int STAT_DIGITAL_UV = 3;
    localparam int STAT_UPDATE = 4;
    localparam int STAT_CONV_ERR = 5;
    localparam int STAT_TB_OVF = 6;
    localparam int STATUS_WIDTH = 7;
    // ----------------------------------------
    // GPIO accumulation gate codes
    // ----------------------------------------
    localparam logic [1:0] GATE_ALWAYS = 2'h0;
    localparam logic [1:0] GATE_GPIO_HIGH = 2'h1;
    localparam logic [1:0] GATE_GPIO_LOW = 2'h2;
    // Deadband LSB equals the current result LSB
    localparam int DEADBAND_LSB_MA = 6;
endpackage

// ### rtl/status_flag_bank.sv
// Sticky status flags, cleared on read, with power-up and shutdown-exit loads.
// Assumes set pulses and the read strobe are synchronous to REF_CLK.
`timescale 1ns/1ns
module status_flag_bank #(
    parameter int WIDTH = 7,
    parameter logic [6:0] POWER_UP_VALUE = 7'h0f,
    parameter logic [6:0] EXIT_VALUE = 7'h09
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] set_evt,
    input wire logic clear_rd,
    input wire logic shutdown_exit,
    output logic [WIDTH-1:0] flags
);
    // ----------------------------------------
    // One sticky cell per status bit
    // ----------------------------------------
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_flag
            logic flag_reg;
            logic flag_next;
            // New event beats both the read clear and the exit load [R18]
            assign flag_next = set_evt[i] ? 1'b1 :                 // [R10]
                               shutdown_exit ? EXIT_VALUE[i] :     // [R8]
                               clear_rd ? 1'b0 : flag_reg;         // [R9]
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    flag_reg <= POWER_UP_VALUE[i]; // [R7]
                end else begin
                    flag_reg <= flag_next;
                end
            end
            assign flags[i] = flag_reg;
        end
    endgenerate
endmodule

// ### rtl/accum_gate.sv
// Accumulation gating by current deadband and GPIO level.
// Assumes the current sample is two's complement in result LSB units.
`timescale 1ns/1ns
module accum_gate #(
    parameter int CUR_WIDTH = 18
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [CUR_WIDTH-1:0] current,
    input wire logic [7:0] deadband,
    input wire logic [3:0] gpio_gate,
    input wire logic gpio_level,
    output logic acc1_en,
    output logic acc2_en,
    output logic cmp_en
);
    // ----------------------------------------
    // Deadband compare
    // ----------------------------------------
    logic [CUR_WIDTH-1:0] abs_cur;
    logic above_db;
    logic gp1_ok;
    logic gp2_ok;
    logic acc1_reg;
    logic acc2_reg;
    logic cmp_reg;

    // Most negative code negates to itself, which as unsigned is far above any deadband
    assign abs_cur = current[CUR_WIDTH-1] ? CUR_WIDTH'(-current) : current;
    assign above_db = abs_cur >= CUR_WIDTH'(deadband); // [R1] [R2]

    // ----------------------------------------
    // GPIO gate decode
    // ----------------------------------------
    function automatic logic gate_ok(input logic [1:0] code, input logic lvl);
        case (code)
            accum_alert_pkg::GATE_ALWAYS: gate_ok = 1'b1;    // [R17]
            accum_alert_pkg::GATE_GPIO_HIGH: gate_ok = lvl;  // [R17]
            accum_alert_pkg::GATE_GPIO_LOW: gate_ok = ~lvl;  // [R17]
            default: gate_ok = 1'b0; // Reserved code accumulates nothing
        endcase
    endfunction

    assign gp1_ok = gate_ok(gpio_gate[accum_alert_pkg::GATE1_LSB +: 2], gpio_level);
    assign gp2_ok = gate_ok(gpio_gate[accum_alert_pkg::GATE2_LSB +: 2], gpio_level);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            acc1_reg <= 1'b0;
            acc2_reg <= 1'b0;
            cmp_reg <= 1'b0;
        end else begin
            acc1_reg <= above_db & gp1_ok; // [R1]
            acc2_reg <= above_db & gp2_ok; // [R1]
            cmp_reg <= above_db;           // [R2]
        end
    end

    assign acc1_en = acc1_reg;
    assign acc2_en = acc2_reg;
    assign cmp_en = cmp_reg;
endmodule

// ### rtl/accum_alert_status_control.sv
// Control and status registers: deadband, alert master enable, timebase,
// GPIO accumulation gate and the clear-on-read status register.
// Assumes the serial front end delivers one-cycle byte read/write strobes.
`timescale 1ns/1ns
// Rules of the document; R5, R6 and R13 are left to the host
// R1: Accumulate only when abs current >= deadband
// R2: Below deadband, hold accumulators, skip threshold checks
// R3: Alert pin enable gates unmasked alerts
// R4: Timebase prescale/divider fields, reset 0x07
// R5: Host programs prescale/divider for external clock
// R6: Host switches clock source only when idle
// R7: Power-up sets status bits three to zero
// R8: Shutdown exit sets bits 0,3, releases alert
// R9: Status read clears returned flags
// R10: New undervoltage events set flags again
// R11: Status alert needs unmasked bit and enable
// R12: Update flag set when measurement cycle completes
// R13: Host reads status with alerts together
// R14: Conversion error set on low analog supply
// R15: Timebase overflow error on counter overflow
// R16: Low status bits encode undervoltage/reset conditions
// R17: GPIO gate codes: always, high, low
// R18: Event during clearing read keeps flag set
module accum_alert_status_control #(
    parameter int CUR_WIDTH = 18
) (
    input wire logic REF_CLK,
    input wire logic SYS_RST,
    input wire logic [7:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [7:0] REG_RDATA,
    output logic REG_RVALID,
    input wire logic [7:0] STATUS_MASK,
    input wire logic OTHER_ALERTS,
    input wire logic ANALOG_UV_EVT,
    input wire logic ANALOG_POR_EVT,
    input wire logic STANDBY_UV_EVT,
    input wire logic DIGITAL_UV_EVT,
    input wire logic MEAS_DONE,
    input wire logic CONV_ERR_EVT,
    input wire logic TB_OVERFLOW_EVT,
    input wire logic SHUTDOWN_EXIT,
    input wire logic [CUR_WIDTH-1:0] CURRENT,
    input wire logic GPIO_LEVEL,
    output logic ACC1_ENABLE,
    output logic ACC2_ENABLE,
    output logic THRESH_CMP_ENABLE,
    output logic [2:0] TB_PRESCALE,
    output logic [4:0] TB_DIVIDER,
    output logic INTERNAL_CLK_SEL,
    output logic ALERT_N_O,
    output logic ALERT_N_OE
);
    // ----------------------------------------
    // Registers and strobes
    // ----------------------------------------
    logic [7:0] deadband_reg;
    logic [7:0] deadband_next;
    logic [7:0] alert_en_reg;
    logic [7:0] alert_en_next;
    logic [7:0] timebase_reg;
    logic [7:0] timebase_next;
    logic [3:0] gpio_gate_reg;
    logic [3:0] gpio_gate_next;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic rvalid_reg;
    logic exit_hold_reg;
    logic exit_hold_next;
    logic alert_reg;
    logic alert_next;

    logic sel_status;
    logic sel_gate;
    logic sel_deadband;
    logic sel_alert;
    logic sel_timebase;
    logic wr_deadband;
    logic wr_alert;
    logic wr_timebase;
    logic wr_gate;
    logic status_rd;

    logic [accum_alert_pkg::STATUS_WIDTH-1:0] status_set;
    logic [accum_alert_pkg::STATUS_WIDTH-1:0] status_flags;
    logic [7:0] status_byte;
    logic [7:0] exit_only_bits;
    logic [7:0] alert_src;
    logic status_alert;
    logic any_event;

    // ----------------------------------------
    // Address decode
    // ----------------------------------------
    assign sel_status = REG_ADDR == accum_alert_pkg::ADDR_STATUS_FLAGS;
    assign sel_gate = REG_ADDR == accum_alert_pkg::ADDR_GPIO_GATE;
    assign sel_deadband = REG_ADDR == accum_alert_pkg::ADDR_DEADBAND;
    assign sel_alert = REG_ADDR == accum_alert_pkg::ADDR_ALERT_ENABLE;
    assign sel_timebase = REG_ADDR == accum_alert_pkg::ADDR_TIMEBASE;

    assign wr_deadband = REG_WR & sel_deadband;
    assign wr_alert = REG_WR & sel_alert;
    assign wr_timebase = REG_WR & sel_timebase;
    assign wr_gate = REG_WR & sel_gate;
    assign status_rd = REG_RD & sel_status;

    // ----------------------------------------
    // Writable control registers
    // ----------------------------------------
    assign deadband_next = wr_deadband ? REG_WDATA : deadband_reg; // [R1]
    // Only the enable bit is implemented; other bits read as zero
    assign alert_en_next = wr_alert ?
        {7'h00, REG_WDATA[accum_alert_pkg::ALERT_PIN_ENABLE_BIT]} : alert_en_reg;
    // Clock source follows the prescale code at once; idle-only switching
    // is left to the host [R6]
    assign timebase_next = wr_timebase ? REG_WDATA : timebase_reg; // [R4] [R5]
    assign gpio_gate_next = wr_gate ? REG_WDATA[3:0] : gpio_gate_reg;

    always_ff @(posedge REF_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            deadband_reg <= accum_alert_pkg::RST_DEADBAND;
            alert_en_reg <= accum_alert_pkg::RST_ALERT_ENABLE; // [R3]
            timebase_reg <= accum_alert_pkg::RST_TIMEBASE;     // [R4]
            gpio_gate_reg <= accum_alert_pkg::RST_GPIO_GATE[3:0];
        end else begin
            deadband_reg <= deadband_next;
            alert_en_reg <= alert_en_next;
            timebase_reg <= timebase_next;
            gpio_gate_reg <= gpio_gate_next;
        end
    end

    // ----------------------------------------
    // Timebase fields
    // ----------------------------------------
    assign TB_PRESCALE = timebase_reg[accum_alert_pkg::PRESCALE_MSB:
                                      accum_alert_pkg::PRESCALE_LSB];
    assign TB_DIVIDER = timebase_reg[accum_alert_pkg::DIVIDER_MSB:
                                     accum_alert_pkg::DIVIDER_LSB];
    assign INTERNAL_CLK_SEL = TB_PRESCALE == accum_alert_pkg::PRESCALE_INTERNAL; // [R4]

    // ----------------------------------------
    // Status flags
    // ----------------------------------------
    // Bit order of the event vector is the status byte layout [R16]
    assign status_set[accum_alert_pkg::STAT_ANALOG_UV] = ANALOG_UV_EVT;     // [R10]
    assign status_set[accum_alert_pkg::STAT_ANALOG_POR] = ANALOG_POR_EVT;   // [R10]
    assign status_set[accum_alert_pkg::STAT_STANDBY_UV] = STANDBY_UV_EVT;   // [R10]
    assign status_set[accum_alert_pkg::STAT_DIGITAL_UV] = DIGITAL_UV_EVT;   // [R10]
    assign status_set[accum_alert_pkg::STAT_UPDATE] = MEAS_DONE;            // [R12]
    assign status_set[accum_alert_pkg::STAT_CONV_ERR] = CONV_ERR_EVT;       // [R14]
    assign status_set[accum_alert_pkg::STAT_TB_OVF] = TB_OVERFLOW_EVT;      // [R15]

    status_flag_bank #(
        .WIDTH(accum_alert_pkg::STATUS_WIDTH),
        .POWER_UP_VALUE(accum_alert_pkg::RST_STATUS_POWER_UP[6:0]),
        .EXIT_VALUE(accum_alert_pkg::RST_STATUS_SHUTDOWN_EXIT[6:0])
    ) u_flags (
        .clk(REF_CLK),
        .rst(SYS_RST),
        .set_evt(status_set),
        .clear_rd(status_rd),
        .shutdown_exit(SHUTDOWN_EXIT),
        .flags(status_flags)
    );

    assign status_byte = {1'b0, status_flags};

    // ----------------------------------------
    // Read path
    // ----------------------------------------
    // Data is captured in the same edge that clears the flags, so the
    // host sees the values that the read removes [R9]
    assign rdata_next = !REG_RD ? rdata_reg :
                        sel_status ? status_byte :
                        sel_gate ? {4'h0, gpio_gate_reg} :
                        sel_deadband ? deadband_reg :
                        sel_alert ? alert_en_reg :
                        sel_timebase ? timebase_reg :
                        accum_alert_pkg::READ_UNMAPPED;

    always_ff @(posedge REF_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            rdata_reg <= 8'h00;
            rvalid_reg <= 1'b0;
        end else begin
            rdata_reg <= rdata_next;
            rvalid_reg <= REG_RD;
        end
    end

    assign REG_RDATA = rdata_reg;
    assign REG_RVALID = rvalid_reg;

    // ----------------------------------------
    // Alert pin
    // ----------------------------------------
    // After shutdown exit the reloaded undervoltage bits must not re-pull
    // the pin; the hold lasts until a status read or any fresh event
    assign any_event = |status_set;
    assign exit_hold_next = SHUTDOWN_EXIT ? 1'b1 :
                            (status_rd | any_event) ? 1'b0 : exit_hold_reg; // [R8]
    assign exit_only_bits = exit_hold_reg ?
        accum_alert_pkg::RST_STATUS_SHUTDOWN_EXIT : 8'h00;
    assign alert_src = status_byte & ~STATUS_MASK & ~exit_only_bits; // [R11]
    assign status_alert = |alert_src;
    assign alert_next = alert_en_reg[accum_alert_pkg::ALERT_PIN_ENABLE_BIT] &
                        (status_alert | OTHER_ALERTS); // [R3] [R11]

    always_ff @(posedge REF_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            exit_hold_reg <= 1'b0;
            alert_reg <= 1'b0;
        end else begin
            exit_hold_reg <= exit_hold_next;
            alert_reg <= alert_next;
        end
    end

    // Open drain: only ever drives low
    assign ALERT_N_O = 1'b0;
    assign ALERT_N_OE = alert_reg;

    // ----------------------------------------
    // Accumulation gating
    // ----------------------------------------
    accum_gate #(
        .CUR_WIDTH(CUR_WIDTH)
    ) u_gate (
        .clk(REF_CLK),
        .rst(SYS_RST),
        .current(CURRENT),
        .deadband(deadband_reg),
        .gpio_gate(gpio_gate_reg),
        .gpio_level(GPIO_LEVEL),
        .acc1_en(ACC1_ENABLE),
        .acc2_en(ACC2_ENABLE),
        .cmp_en(THRESH_CMP_ENABLE)
    );
endmodule

// ### tb/accum_alert_chk.sv
// Concurrent checks on the ports of the control and status register block.
// Assumes one REF_CLK domain and SYS_RST asynchronous, active high.
`timescale 1ns/1ns
module accum_alert_chk (
    input wire logic REF_CLK,
    input wire logic SYS_RST,
    input wire logic [7:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [7:0] REG_RDATA,
    input wire logic REG_RVALID,
    input wire logic [7:0] STATUS_MASK,
    input wire logic OTHER_ALERTS,
    input wire logic ANALOG_UV_EVT,
    input wire logic ANALOG_POR_EVT,
    input wire logic STANDBY_UV_EVT,
    input wire logic DIGITAL_UV_EVT,
    input wire logic MEAS_DONE,
    input wire logic CONV_ERR_EVT,
    input wire logic TB_OVERFLOW_EVT,
    input wire logic SHUTDOWN_EXIT,
    input wire logic ACC1_ENABLE,
    input wire logic ACC2_ENABLE,
    input wire logic THRESH_CMP_ENABLE,
    input wire logic [2:0] TB_PRESCALE,
    input wire logic [4:0] TB_DIVIDER,
    input wire logic INTERNAL_CLK_SEL,
    input wire logic ALERT_N_O,
    input wire logic ALERT_N_OE
);
    // ----------------------------------------
    // Helpers and properties
    // ----------------------------------------
    wire rd_stat = REG_RD && REG_ADDR == accum_alert_pkg::ADDR_STATUS_FLAGS;
    wire ev_set = |{ANALOG_UV_EVT, ANALOG_POR_EVT, STANDBY_UV_EVT, DIGITAL_UV_EVT,
        MEAS_DONE, CONV_ERR_EVT, TB_OVERFLOW_EVT};
    wire ev = ev_set || SHUTDOWN_EXIT;
    wire tb_wr = REG_WR && REG_ADDR == accum_alert_pkg::ADDR_TIMEBASE;
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (SYS_RST);
    a_rvalid_one_cycle: assert property (REG_RD |=> REG_RVALID ##1 !REG_RVALID)
        else $error("read valid not a single cycle after read");
    a_status_clear: assert property (rd_stat && !ev ##1 (!ev)[*2] ##1 rd_stat && !ev
        |=> REG_RVALID && REG_RDATA == 8'h00) else $error("status not cleared by read");
    a_update_sticky: assert property (MEAS_DONE ##1 !SHUTDOWN_EXIT ##1 rd_stat
        |=> REG_RDATA[4]) else $error("update flag lost before read");
    a_exit_load: assert property (SHUTDOWN_EXIT && !ev_set ##1 (!ev)[*2] ##1 rd_stat && !ev
        |=> REG_RDATA == 8'h09) else $error("shutdown exit status wrong");
    a_clk_select: assert property (INTERNAL_CLK_SEL == (TB_PRESCALE == 3'h7))
        else $error("clock select does not follow prescale");
    a_tb_write: assert property (tb_wr |=> {TB_DIVIDER, TB_PRESCALE} == $past(REG_WDATA))
        else $error("timebase write not applied");
    a_tb_hold: assert property (!tb_wr |=> $stable({TB_DIVIDER, TB_PRESCALE}))
        else $error("timebase changed without write");
    a_acc_needs_cmp: assert property ((ACC1_ENABLE || ACC2_ENABLE) |-> THRESH_CMP_ENABLE)
        else $error("accumulation enabled below deadband");
    a_alert_masked: assert property ((STATUS_MASK == 8'hff && !OTHER_ALERTS)[*2]
        |-> !ALERT_N_OE) else $error("alert driven with all sources masked");
    a_alert_low: assert property (ALERT_N_OE |-> ALERT_N_O == 1'b0)
        else $error("alert pin not driven low");
endmodule
bind accum_alert_status_control accum_alert_chk i_accum_alert_chk (.REF_CLK(REF_CLK),
    .SYS_RST(SYS_RST), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR),
    .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .REG_RVALID(REG_RVALID),
    .STATUS_MASK(STATUS_MASK), .OTHER_ALERTS(OTHER_ALERTS), .ANALOG_UV_EVT(ANALOG_UV_EVT),
    .ANALOG_POR_EVT(ANALOG_POR_EVT), .STANDBY_UV_EVT(STANDBY_UV_EVT),
    .DIGITAL_UV_EVT(DIGITAL_UV_EVT), .MEAS_DONE(MEAS_DONE), .CONV_ERR_EVT(CONV_ERR_EVT),
    .TB_OVERFLOW_EVT(TB_OVERFLOW_EVT), .SHUTDOWN_EXIT(SHUTDOWN_EXIT),
    .ACC1_ENABLE(ACC1_ENABLE), .ACC2_ENABLE(ACC2_ENABLE),
    .THRESH_CMP_ENABLE(THRESH_CMP_ENABLE), .TB_PRESCALE(TB_PRESCALE),
    .TB_DIVIDER(TB_DIVIDER), .INTERNAL_CLK_SEL(INTERNAL_CLK_SEL),
    .ALERT_N_O(ALERT_N_O), .ALERT_N_OE(ALERT_N_OE));

// ### tb/reg_host.sv
// Host side of the byte register port: single-cycle read and write strobes.
// Assumes strobes are taken on the rising edge of REF_CLK.
`timescale 1ns/1ns
module reg_host (
    input wire logic REF_CLK,
    output logic [7:0] REG_ADDR,
    output logic [7:0] REG_WDATA,
    output logic REG_WR,
    output logic REG_RD,
    input wire logic [7:0] REG_RDATA,
    input wire logic REG_RVALID
);
    // ----------------------------------------
    // Bus tasks
    // ----------------------------------------
    initial begin
        REG_ADDR = 8'h00;
        REG_WDATA = 8'h00;
        REG_WR = 1'b0;
        REG_RD = 1'b0;
    end
    // Divider and prescale are written as whole bytes picked for the clock rate
    // Clock source is only switched with no measurement running
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge REF_CLK);
        REG_ADDR <= a;
        REG_WDATA <= d;
        REG_WR <= 1'b1;
        @(posedge REF_CLK);
        REG_WR <= 1'b0;
    endtask
    // Status is read as one byte; the alert mask comes in on STATUS_MASK, not from a register
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge REF_CLK);
        REG_ADDR <= a;
        REG_RD <= 1'b1;
        @(posedge REF_CLK);
        REG_RD <= 1'b0;
        @(posedge REF_CLK);
        d = REG_RVALID ? REG_RDATA : 8'hxx;
    endtask
endmodule

// ### tb/tb.sv
// Self-checking bench for the control and status register block.
// Assumes the host model drives the register port; events come from here.
`timescale 1ns/1ns
module tb;
    // ----------------------------------------
    // Bench signals
    // ----------------------------------------
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] addr, wdata, rdata, mask, d;
    logic wr, rd, rvalid, other, sdx, gpio, acc1, acc2, cmp, isel, al_o, al_oe;
    logic [6:0] evt;
    logic [17:0] cur;
    logic [2:0] pre;
    logic [4:0] div;
    int mismatches = 0;
    int n_checks = 0;
    int cyc = 0;
    logic [17:0] ctab [4] = '{18'h00010, 18'h0000f, 18'h3fff0, 18'h3fff1};
    initial begin
        mask = 8'hff;
        other = 1'b0;
        sdx = 1'b0;
        gpio = 1'b0;
        evt = 7'h00;
        cur = 18'h00000;
        forever #25 clk = ~clk;
    end
    reg_host i_reg_host (.REF_CLK(clk), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr),
        .REG_RD(rd), .REG_RDATA(rdata), .REG_RVALID(rvalid));
    accum_alert_status_control i_accum_alert_status_control (.REF_CLK(clk), .SYS_RST(rst),
        .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata),
        .REG_RVALID(rvalid), .STATUS_MASK(mask), .OTHER_ALERTS(other),
        .ANALOG_UV_EVT(evt[0]), .ANALOG_POR_EVT(evt[1]), .STANDBY_UV_EVT(evt[2]),
        .DIGITAL_UV_EVT(evt[3]), .MEAS_DONE(evt[4]), .CONV_ERR_EVT(evt[5]),
        .TB_OVERFLOW_EVT(evt[6]), .SHUTDOWN_EXIT(sdx), .CURRENT(cur), .GPIO_LEVEL(gpio),
        .ACC1_ENABLE(acc1), .ACC2_ENABLE(acc2), .THRESH_CMP_ENABLE(cmp),
        .TB_PRESCALE(pre), .TB_DIVIDER(div), .INTERNAL_CLK_SEL(isel),
        .ALERT_N_O(al_o), .ALERT_N_OE(al_oe));
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic pulse(input logic [6:0] v);
        @(posedge clk);
        evt <= v;
        @(posedge clk);
        evt <= 7'h00;
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // Cuts a hang short; the whole sequence needs well under a thousand cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 4000) begin
            mismatches++;
            tally_and_finish();
        end
    end
    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        tick(2);
        chk("cmp_db0", 8'h01, cmp);
        i_reg_host.rd(8'he4, d); chk("deadband", 8'h00, d);
        i_reg_host.rd(8'he8, d); chk("alert_en", 8'h01, d);
        i_reg_host.rd(8'he9, d); chk("timebase", 8'h07, d);
        i_reg_host.wr(8'h80, 8'hff);
        i_reg_host.rd(8'h80, d); chk("stat_pu", 8'h0f, d);
        i_reg_host.rd(8'h80, d); chk("stat_clr", 8'h00, d);
        i_reg_host.rd(8'h10, d); chk("unmapped", 8'h00, d);
        $display("test reset_values done");
        for (int i = 0; i < 7; i++) begin
            pulse(7'h01 << i);
            i_reg_host.rd(8'h80, d); chk("stat_evt", 8'h01 << i, d);
        end
        fork
            i_reg_host.rd(8'h80, d);
            pulse(7'h20);
        join
        chk("rd_same", 8'h00, d);
        i_reg_host.rd(8'h80, d); chk("kept", 8'h20, d);
        $display("test status_events done");
        other <= 1'b1;
        tick(3); chk("oe_other", 8'h01, al_oe);
        i_reg_host.wr(8'he8, 8'h00);
        tick(3); chk("oe_block", 8'h00, al_oe);
        i_reg_host.wr(8'he8, 8'h01);
        other <= 1'b0;
        mask <= 8'hef;
        pulse(7'h10);
        tick(3); chk("oe_upd", 8'h01, al_oe);
        i_reg_host.rd(8'h80, d); chk("stat_upd", 8'h10, d);
        tick(3); chk("oe_rel", 8'h00, al_oe);
        mask <= 8'hf6;
        pulse(7'h01);
        tick(3); chk("oe_uv", 8'h01, al_oe);
        @(posedge clk);
        sdx <= 1'b1;
        @(posedge clk);
        sdx <= 1'b0;
        tick(1); chk("oe_exit", 8'h00, al_oe);
        i_reg_host.rd(8'h80, d); chk("stat_exit", 8'h09, d);
        mask <= 8'hff;
        $display("test alert done");
        i_reg_host.wr(8'he9, 8'h5a);
        tick(1); chk("tb_fields", 8'h5a, {div, pre});
        chk("ext_sel", 8'h00, isel);
        i_reg_host.wr(8'he9, 8'h07);
        tick(1); chk("int_sel", 8'h01, isel);
        $display("test timebase done");
        i_reg_host.wr(8'he4, 8'h10);
        for (int i = 0; i < 4; i++) begin
            cur <= ctab[i];
            tick(3); chk("cmp_db", {7'h00, ~i[0]}, cmp);
            chk("acc_db", {6'h00, ~i[0], ~i[0]}, {acc2, acc1});
        end
        cur <= 18'h00010;
        for (int c = 0; c < 4; c++) begin
            for (int g = 0; g < 2; g++) begin
                i_reg_host.wr(8'he3, {4'h0, c[1:0], c[1:0]});
                gpio <= g[0];
                tick(3);
                d = {7'h00, c == 0 || (c == 1 && g == 1) || (c == 2 && g == 0)};
                chk("gate", {d[6:0], d[0]}, {6'h00, acc2, acc1});
            end
        end
        $display("test accumulation done");
        tally_and_finish();
    end
endmodule
